// >>> bench/cst_cpu_model.sv
/*
 * cpu local bus model for the cache test-mode block.
 * assumes the block returns rdy_n low for tag test window cycles only.
 */
`timescale 1ns/1ps
module cst_cpu_model (
	// clock
	input wire logic clk,
	// bus cycle
	output logic ads_n,
	output logic [31:0] cpu_addr,
	output logic cpu_write,
	output logic cpu_mem,
	// answer
	input wire logic rdy_n
);
	// bus idle at time zero
	initial begin
		ads_n = 1'b1;
		cpu_addr = 32'h0;
		cpu_write = 1'b0;
		cpu_mem = 1'b1;
	end

	// address only, no strobe: used for steering checks
	task automatic put_addr(input logic [31:0] a, input logic w);
		@(negedge clk);
		cpu_addr = a;
		cpu_write = w;
	endtask

	// strobed cycle held until ready; n counts edges, 0 on timeout
	// internal cache assumed off, so every access shows here
	task automatic bus_cycle(input logic [31:0] a, input logic w,
		input logic wait_rdy, output int n);
		@(negedge clk);
		cpu_addr = a;
		cpu_write = w;
		ads_n = 1'b0;
		n = 0;
		for (int i = 1; i < 16; i++) begin
			@(negedge clk);
			ads_n = 1'b1;
			if (!wait_rdy || rdy_n === 1'b0) begin
				n = i;
				break;
			end
		end
		// ready is taken at the next rising edge; hold until then
		@(posedge clk);
		@(negedge clk);
		// stale address would hide decode faults, so flip it
		cpu_addr = ~a;
	endtask
endmodule // cst_cpu_model

// >>> bench/tb_cache_sram_tag_test_modes.sv
/*
 * self-checking bench for the cache sram / tag test-mode logic.
 * assumes the cpu model drives the bus; dram side answers elsewhere.
 */
`timescale 1ns/1ps
module tb_cache_sram_tag_test_modes;
	logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_index = 8'h0, reg_wdata = 8'h0, reg_rdata;
	logic sram_test_en = 1'b0, tag_test_en = 1'b0, win_at_1m = 1'b0;
	logic [2:0] cache_size = 3'h0;
	logic dual_bank = 1'b0, tag_wr_slow = 1'b0, cacheable_in_n = 1'b1;
	logic [5:0] nrm = 6'h0;
	logic ads_n, cpu_write, cpu_mem, rdy_n, burst_transfer_ready_n;
	logic [31:0] cpu_addr;
	logic tag_hit, cache_cacheable, line_fill, castout, tag_we;
	logic dram_wr_fwd, dram_sees_hit, sram_enable, cache_sram_addr_bit2;
	logic cacheable_indicator_n, tag_busy;
	int bad_count = 0, comparisons = 0;

	cst_test_ctl u_dut (.clk, .reset, .ads_n, .cpu_addr, .cpu_write,
		.cpu_mem, .reg_wr, .reg_rd, .reg_index, .reg_wdata, .sram_test_en,
		.tag_test_en, .win_at_1m, .cache_size, .dual_bank, .tag_wr_slow,
		.norm_tag_hit(nrm[5]), .norm_cacheable(nrm[4]), .norm_fill(nrm[3]),
		.norm_castout(nrm[2]), .norm_tag_we(nrm[1]), .norm_dram_wr(nrm[0]),
		.cacheable_in_n, .reg_rdata, .tag_hit, .cache_cacheable, .line_fill,
		.castout, .tag_we, .dram_wr_fwd, .dram_sees_hit, .sram_enable,
		.cache_sram_addr_bit2, .cacheable_indicator_n, .rdy_n,
		.burst_transfer_ready_n, .tag_busy);
	cst_cpu_model u_cpu (.clk, .ads_n, .cpu_addr, .cpu_write, .cpu_mem,
		.rdy_n);

	// 40 mhz
	always #12.5 clk = ~clk;

	// --------------------------------------------------------------
	// checking helpers
	// --------------------------------------------------------------
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] ex);
		comparisons++;
		if (seen !== ex) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	// low window depends on size code; high window fixed
	function automatic logic exp_win(logic [31:0] a, logic hi,
		logic [2:0] sz);
		if (hi) return a >= 32'h10_0000 && a < 32'h18_0000;
		if (sz == 3'h3) return a >= 32'h2_0000 && a < 32'ha_0000;
		return a >= 32'h4_0000 && a < 32'h8_0000;
	endfunction

	// low 512k window folds its top 128k onto sram 0 in test modes
	function automatic logic [31:0] exp_map(logic [31:0] a, logic t,
		logic hi, logic [2:0] sz);
		if (t && !hi && sz == 3'h3 && a >= 32'h8_0000 && a < 32'ha_0000)
			return a & 32'h1_ffff;
		return a;
	endfunction

	task automatic rw(input logic [7:0] i, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_index = i;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rr(input logic [7:0] i, output logic [7:0] d);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_index = i;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask

	// ex is the edge count to ready; 0 means no ready expected here
	task automatic cyc(input logic [31:0] a, input logic w, input int ex);
		int n;
		u_cpu.bus_cycle(a, w, ex != 0, n);
		if (n == 0) begin
			bad_count++;
			wrap_up();
		end
		chk("edges", n, (ex == 0) ? 1 : ex);
		chk("burst", burst_transfer_ready_n, 1'b1);
		chk("busy", tag_busy, 1'b0);
		if (ex == 0) chk("no_rdy", rdy_n, 1'b1);
	endtask

	// outputs follow address and engine inputs one cycle later
	task automatic steer(input logic [31:0] a, input logic dual);
		logic win, t, kin;
		logic [5:0] ex, m;
		logic [31:0] sa;
		u_cpu.put_addr(a, 1'($urandom));
		nrm = 6'($urandom);
		dual_bank = dual;
		kin = 1'($urandom);
		cacheable_in_n = kin;
		win = exp_win(a, win_at_1m, cache_size);
		t = sram_test_en | tag_test_en;
		sa = exp_map(a, t, win_at_1m, cache_size);
		@(negedge clk);
		ex = t ? {sram_test_en & win, 5'h0} : nrm;
		m = t ? {1'b1, ~win, 3'h7, win & cpu_write} : 6'h3f;
		chk("steer", {tag_hit, cache_cacheable, line_fill, castout, tag_we,
			dram_wr_fwd} & m, ex & m);
		if (t) chk("dram_hit", dram_sees_hit, win);
		else chk("dram_hit", dram_sees_hit, nrm[5]);
		chk("sram_en", sram_enable, t ? sram_test_en & win : 1'b1);
		chk("ca2", cache_sram_addr_bit2,
			dual ? sa[16 + cache_size] : sa[2]);
		chk("ken", cacheable_indicator_n, kin);
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		static logic [31:0] cn [12] = '{32'h1_ffff, 32'h2_0000, 32'h3_ffff,
			32'h4_0000, 32'h7_ffff, 32'h8_0000, 32'h9_ffff, 32'ha_0000,
			32'hf_ffff, 32'h10_0000, 32'h17_ffff, 32'h18_0000};
		logic [7:0] lo [8];
		logic [7:0] hi [8];
		logic [7:0] d;
		logic [31:0] b;
		void'($urandom(32'h77df));
		repeat (16) @(negedge clk);
		chk("rst", {rdy_n, burst_transfer_ready_n, cacheable_indicator_n,
			sram_enable, tag_we}, 5'h1e);
		reset = 1'b0;
		// every mode, location and size (size code 4 at 1m only); engine bits random
		for (int md = 0; md < 3; md++) begin
			for (int h = 0; h < 2; h++) begin
				for (int s = 0; s < 4 + h; s++) begin
					@(negedge clk);
					sram_test_en = md == 1;
					tag_test_en = md == 2;
					win_at_1m = h[0];
					cache_size = 3'(s);
					foreach (cn[k]) steer(cn[k], 1'($urandom));
					steer({11'h0, 21'($urandom)}, 1'($urandom));
				end
			end
		end
		// size probe then bank probe, as start-up software does it
		sram_test_en = 1'b1;
		tag_test_en = 1'b0;
		win_at_1m = 1'b1;
		for (int j = 4; j > 0; j--) begin
			cache_size = 3'(j);
			steer(32'h10_0000 | (32'h1 << (14 + j)), 1'b1);
		end
		steer(32'h10_000c, 1'b0);
		win_at_1m = 1'b0;
		cache_size = 3'h3;
		steer(32'h9_fff4, 1'b1);
		$display("test steer done");
		// tag writes through the index registers, fast and slow
		sram_test_en = 1'b0;
		tag_test_en = 1'b1;
		win_at_1m = 1'b1;
		b = 32'h10_0000;
		for (int i = 0; i < 8; i++) begin
			lo[i] = 8'($urandom);
			hi[i] = 8'($urandom);
			rw(8'h23, lo[i]);
			rw(8'h24, hi[i]);
			tag_wr_slow = i[0];
			cyc(b + 32'(16 * i) + 32'($urandom % 16), 1'b1, 2 + i % 2);
		end
		cyc(b + 32'h70, 1'b0, 1);
		rw(8'h23, ~lo[7]);
		rr(8'h23, d);
		chk("rd_reg", d, lo[7]);
		// read back with another byte of each line
		for (int i = 0; i < 8; i++) begin
			cyc(b + 32'(16 * i) + 32'(15 - i), 1'b0, 1);
			rr(8'h23, d);
			chk("tag_lo", d, lo[i]);
			rr(8'h24, d);
			chk("tag_hi", d, hi[i]);
		end
		cyc(32'h4_0000, 1'b0, 0);
		rr(8'h24, d);
		chk("hold", d, hi[7]);
		rr(8'h25, d);
		chk("unmapped", d, 8'h0);
		$display("test tag done");
		wrap_up();
	end
endmodule // tb_cache_sram_tag_test_modes

// >>> hdl/cst_tag_ram.sv
/*
 * tag ram model: one entry per 16-byte line, registered read data.
 * assumes one access per clock; a read in a write cycle returns the old entry.
 */
`timescale 1ns/1ps
module cst_tag_ram #(
	parameter int AW = 16,
	parameter int DW = 16
) (
	// clock
	input wire logic clk,
	// access
	input wire logic wr_en,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wr_data,
	// read
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [2**AW];

	// refuse sizes the address slice and tag registers cannot serve
	if (AW < 1 || AW > 20 || DW < 1 || DW > 16) begin : g_bad_size
		$error("cst_tag_ram: unsupported size");
	end

	// read data out of a register so the capture path has no comb ram
	always_ff @(posedge clk) begin
		if (wr_en)
			mem[addr] <= wr_data;
		rd_data <= mem[addr];
	end
endmodule // cst_tag_ram

// >>> hdl/cst_test_ctl.sv
/*
 * cache data sram and tag ram test-mode control.
 * assumes cpu bus cycles are framed by ads_n (t1) and the cycle end
 * is marked by the ready strobes this block or the dram side returns.
 * the normal cache engine owns the sram/tag when both modes are off.
 */
`timescale 1ns/1ps
`include "cst_defs.svh"

// Summary of operation
// - sram test mode forces a hit for every cycle inside the window
// - sram test uses programmed hit timing; writes as write-hit-dirty
// - in any test mode, cycles outside the window are uncached, no fill
// - dram logic is told window cycles are hits
// - window writes never forwarded to dram in test modes
// - size bits only pick window size below 1m in test modes
// - cacheable indicator passes through unaltered
// - tag test regs: separate write and read registers
// - tag test read latches tag at end of t2, zero waits, single ready
// - tag test write stores write regs to tag, one or two waits
// - tag entry per 16-byte line, indexed from address bit 4
// - data srams disabled in tag test mode while sram test is off
// - window decode replaces the tag hit in sram test mode, and the dram hit in both test modes
// - dual bank: cache size selects address bit for sram bit 2
// - window location bit picks low or 1m window
// - low 512k window folds 80000-9ffff onto sram 0-1ffff
module cst_test_ctl
	import cst_pkg::*;
#(
	parameter int TAG_AW = 16,
	parameter int TAG_DW = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// cpu bus cycle
	input wire logic ads_n,
	input wire logic [31:0] cpu_addr,
	input wire logic cpu_write,
	input wire logic cpu_mem,
	// index register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_index,
	input wire logic [7:0] reg_wdata,
	// configuration bits
	input wire logic sram_test_en,
	input wire logic tag_test_en,
	input wire logic win_at_1m,
	input wire logic [2:0] cache_size,
	input wire logic dual_bank,
	input wire logic tag_wr_slow,
	// normal engine and pass-through
	input wire logic norm_tag_hit,
	input wire logic norm_cacheable,
	input wire logic norm_fill,
	input wire logic norm_castout,
	input wire logic norm_tag_we,
	input wire logic norm_dram_wr,
	input wire logic cacheable_in_n,
	// register read
	output logic [7:0] reg_rdata,
	// cache / cpu side
	output logic tag_hit,
	output logic cache_cacheable,
	output logic line_fill,
	output logic castout,
	output logic tag_we,
	output logic dram_wr_fwd,
	output logic dram_sees_hit,
	output logic sram_enable,
	output logic cache_sram_addr_bit2,
	output logic cacheable_indicator_n,
	output logic rdy_n,
	output logic burst_transfer_ready_n,
	output logic tag_busy
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		cst_state_t st;
		logic [1:0] ws;
		logic [TAG_DW-1:0] wr_tag;
		logic [TAG_DW-1:0] rd_tag;
		logic [7:0] rdata;
		logic hit;
		logic cach;
		logic fill;
		logic cout;
		logic twe;
		logic dwr;
		logic dhit;
		logic sen;
		logic ca2;
		logic ken_n;
		logic rdy_n;
		logic burst_transfer_ready_n_n;
		logic busy;
	} cst_regs_t;

	cst_regs_t r_ff, nxt_r;
	logic in_win;
	logic [31:0] sram_addr;
	logic [TAG_DW-1:0] tag_q;
	logic any_test;
	logic tag_wr_go;
	logic tag_rd_go;

	// two index registers carry at most 16 tag bits, at least 9
	if (TAG_DW < 9 || TAG_DW > 16 || TAG_AW < 12 || TAG_AW > 16)
	begin : g_bad_size
		$error("cst_test_ctl: unsupported tag size");
	end

	// ------------------------------------------------------------
	// window decode and tag ram
	// ------------------------------------------------------------
	cst_window u_win (
		.win_at_1m(win_at_1m),
		.cache_size(cache_size),
		.cpu_addr(cpu_addr),
		.in_window(in_win),
		.sram_addr(sram_addr)
	);

	assign any_test = sram_test_en | tag_test_en;
	assign tag_rd_go = !ads_n && cpu_mem && tag_test_en && in_win &&
		!cpu_write;
	assign tag_wr_go = !ads_n && cpu_mem && tag_test_en && in_win &&
		cpu_write;

	cst_tag_ram #(.AW(TAG_AW), .DW(TAG_DW)) u_tag (
		.clk(clk),
		.wr_en(tag_wr_go),
		.addr(cpu_addr[`CST_LINE_SHIFT +: TAG_AW]),
		.wr_data(r_ff.wr_tag),
		.rd_data(tag_q)
	);

	// picks the cpu address bit that feeds sram bit 2 in dual bank
	function automatic logic ca2_sel(input logic [2:0] sz,
		input logic [31:0] a, input logic dual);
		logic b;
		b = a[2];
		if (dual) begin
			unique case (sz)
				`CST_SZ_64K: b = a[16];
				`CST_SZ_128K: b = a[17];
				`CST_SZ_256K: b = a[18];
				`CST_SZ_512K: b = a[19];
				default: b = a[20];
			endcase
		end
		return b;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_r = r_ff;
		nxt_r.rdy_n = 1'b1;
		nxt_r.burst_transfer_ready_n_n = 1'b1;
		nxt_r.twe = 1'b0;
		// registers: write side only feeds the tag ram
		if (reg_wr && reg_index == `CST_IDX_TAG_LO)
			nxt_r.wr_tag[7:0] = reg_wdata;
		if (reg_wr && reg_index == `CST_IDX_TAG_HI)
			nxt_r.wr_tag[TAG_DW-1:8] = reg_wdata[TAG_DW-9:0];
		// read side returns the captured tag, zero for any other index
		if (reg_rd && reg_index == `CST_IDX_TAG_LO)
			nxt_r.rdata = r_ff.rd_tag[7:0];
		else if (reg_rd && reg_index == `CST_IDX_TAG_HI)
			nxt_r.rdata = 8'(r_ff.rd_tag[TAG_DW-1:8]);
		else if (reg_rd)
			nxt_r.rdata = 8'h00;
		// cache control steering
		if (any_test) begin
			nxt_r.hit = in_win & sram_test_en;
			nxt_r.dhit = in_win;
			nxt_r.cach = 1'b0;
			nxt_r.fill = 1'b0;
			nxt_r.cout = 1'b0;
			nxt_r.dwr = in_win ? 1'b0 : norm_dram_wr;
			nxt_r.sen = sram_test_en && in_win;
		end else begin
			nxt_r.hit = norm_tag_hit;
			nxt_r.dhit = norm_tag_hit;
			nxt_r.cach = norm_cacheable;
			nxt_r.fill = norm_fill;
			nxt_r.cout = norm_castout;
			nxt_r.dwr = norm_dram_wr;
			nxt_r.sen = 1'b1;
		end
		if (!tag_test_en && norm_tag_we && !any_test)
			nxt_r.twe = 1'b1;
		// the low-window fold only applies while a test mode runs
		nxt_r.ca2 = ca2_sel(cache_size, any_test ? sram_addr : cpu_addr,
			dual_bank);
		nxt_r.ken_n = cacheable_in_n;
		// tag test cycle sequencer
		unique case (r_ff.st)
			CST_IDLE: begin
				if (tag_rd_go) begin
					// zero waits: ready stands at the end of t2
					nxt_r.st = CST_TAG_RD;
					nxt_r.busy = 1'b1;
					nxt_r.rdy_n = 1'b0;
				end else if (tag_wr_go) begin
					nxt_r.st = CST_TAG_WR;
					nxt_r.ws = tag_wr_slow ? `CST_TAG_WS_LONG :
						`CST_TAG_WS_SHORT;
					nxt_r.busy = 1'b1;
					nxt_r.twe = 1'b1;
				end
			end
			CST_TAG_RD: begin
				// t2 end: capture what the ram read out at the strobe
				nxt_r.rd_tag = tag_q;
				nxt_r.busy = 1'b0;
				nxt_r.st = CST_IDLE;
			end
			CST_TAG_WR: begin
				if (r_ff.ws == `CST_TAG_WS_SHORT) begin
					nxt_r.rdy_n = 1'b0;
					nxt_r.st = CST_PASS;
				end else
					nxt_r.ws = r_ff.ws - 2'h1;
			end
			CST_PASS: begin
				// ready stands in this cycle; back to idle at its closing edge, no extra cycle
				nxt_r.busy = 1'b0;
				nxt_r.st = CST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			r_ff <= '0;
			r_ff.st <= CST_IDLE;
			r_ff.ken_n <= 1'b1;
			r_ff.rdy_n <= 1'b1;
			r_ff.burst_transfer_ready_n_n <= 1'b1;
			r_ff.sen <= 1'b1;
		end else
			r_ff <= nxt_r;
	end

	assign reg_rdata = r_ff.rdata;
	assign tag_hit = r_ff.hit;
	assign cache_cacheable = r_ff.cach;
	assign line_fill = r_ff.fill;
	assign castout = r_ff.cout;
	assign tag_we = r_ff.twe;
	assign dram_wr_fwd = r_ff.dwr;
	assign dram_sees_hit = r_ff.dhit;
	assign sram_enable = r_ff.sen;
	assign cache_sram_addr_bit2 = r_ff.ca2;
	assign cacheable_indicator_n = r_ff.ken_n;
	assign rdy_n = r_ff.rdy_n;
	assign burst_transfer_ready_n = r_ff.burst_transfer_ready_n_n;
	assign tag_busy = r_ff.busy;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_tag_rd_ready: assert property (tag_rd_go && r_ff.st == CST_IDLE
		|=> !rdy_n) else $error("tag read ready late");
	a_no_burst: assert property (tag_test_en |=> burst_transfer_ready_n)
		else $error("burst ready in tag test");
	a_tag_wr_fast: assert property (tag_wr_go && !tag_wr_slow &&
		r_ff.st == CST_IDLE |=> ##1 !rdy_n)
		else $error("tag write wait wrong");
	a_tag_wr_slow: assert property (tag_wr_go && tag_wr_slow &&
		r_ff.st == CST_IDLE |=> ##2 !rdy_n)
		else $error("slow tag write wait wrong");
	a_force_hit: assert property (sram_test_en && in_win |=> tag_hit)
		else $error("no forced hit");
	a_no_fill: assert property (any_test |=> !line_fill && !castout)
		else $error("fill in test mode");
	a_no_dram_wr: assert property (any_test && in_win |=> !dram_wr_fwd)
		else $error("window write reached dram");
	a_sram_off: assert property (tag_test_en && !sram_test_en |=>
		!sram_enable) else $error("sram on in tag test");
	a_ken_pass: assert property (1'b1 |=> cacheable_indicator_n ==
		$past(cacheable_in_n)) else $error("ken altered");
	a_rd_hold: assert property (r_ff.st != CST_TAG_RD |=>
		$stable(r_ff.rd_tag)) else $error("tag read reg moved");
	c_tag_rd: cover property (tag_rd_go ##1 !rdy_n);
	c_tag_wr: cover property (tag_wr_go ##2 !rdy_n);
	c_sram_hit: cover property (sram_test_en && in_win ##1 tag_hit);
endmodule // cst_test_ctl

// >>> hdl/cst_window.sv
/*
 * test window decode and sram address mapping.
 * assumes the address is stable for the whole cycle.
 */
`timescale 1ns/1ps
`include "cst_defs.svh"
module cst_window (
	// configuration
	input wire logic win_at_1m,
	input wire logic [2:0] cache_size,
	// address
	input wire logic [31:0] cpu_addr,
	// results
	output logic in_window,
	output logic [31:0] sram_addr
);
	logic is512;

	// only below 1m does cache size matter: it sets window size and the fold
	always_comb begin
		is512 = (cache_size == `CST_SZ_512K);
		sram_addr = cpu_addr;
		if (win_at_1m)
			in_window = cpu_addr >= `CST_WIN_HI_BASE &&
				cpu_addr < `CST_WIN_HI_END;
		else if (is512)
			in_window = cpu_addr >= `CST_WIN_LO_512_BASE &&
				cpu_addr < `CST_WIN_LO_512_END;
		else
			in_window = cpu_addr >= `CST_WIN_LO_256_BASE &&
				cpu_addr < `CST_WIN_LO_256_END;
		// top 128k of the low 512k window folds onto sram 0
		if (!win_at_1m && is512 && cpu_addr >= `CST_REMAP_BASE &&
			cpu_addr < `CST_WIN_LO_512_END)
			sram_addr = cpu_addr & `CST_REMAP_MASK;
	end
endmodule // cst_window

// >>> include/cst_defs.svh
/*
 * constants for the cache sram / tag test-mode logic.
 * assumes a 32-bit cpu address (a31..a2 plus byte enables) on the local bus.
 */
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

// ----------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------
`define CST_IDX_TAG_LO 8'h23
`define CST_IDX_TAG_HI 8'h24

// ----------------------------------------------------------------
// cache size codes
// ----------------------------------------------------------------
`define CST_SZ_64K 3'h0
`define CST_SZ_128K 3'h1
`define CST_SZ_256K 3'h2
`define CST_SZ_512K 3'h3
`define CST_SZ_1M 3'h4

// ----------------------------------------------------------------
// test window bounds, byte addresses (upper limits exclusive)
// ----------------------------------------------------------------
`define CST_WIN_LO_256_BASE 32'h0004_0000
`define CST_WIN_LO_256_END 32'h0008_0000
`define CST_WIN_LO_512_BASE 32'h0002_0000
`define CST_WIN_LO_512_END 32'h000a_0000
`define CST_WIN_HI_BASE 32'h0010_0000
`define CST_WIN_HI_END 32'h0018_0000
`define CST_REMAP_BASE 32'h0008_0000
`define CST_REMAP_MASK 32'h0001_ffff

// ----------------------------------------------------------------
// tag line geometry and timing
// ----------------------------------------------------------------
`define CST_LINE_SHIFT 4
`define CST_TAG_WS_SHORT 2'h1
`define CST_TAG_WS_LONG 2'h2

`endif

// >>> include/cst_pkg.sv
/*
 * types for the cache sram / tag test-mode logic.
 * assumes cst_defs.svh holds all numeric constants.
 */
package cst_pkg;
	// test cycle sequencer states
	typedef enum logic [1:0] {
		CST_IDLE,
		CST_TAG_RD,
		CST_TAG_WR,
		CST_PASS
	} cst_state_t;
endpackage
